/* sbha_pkg.sv */
// Operation
// - hold request to the cpu is a flop on the cpu clock.
// - each local master request competes with the others, dma and cpu.
// - a local master owns the bus while its active-low grant is low.
// - two extra local request/grant pairs exist on shared pins.
// - the second local request is arbitrated against the other local requests.
// - with preemption on, an unmasked dma request removes a local master.
// - dma grant pin goes low while dma or an isa master owns the bus.
// - during power-fail or system reset the dma grant pin is a strap input.
// - write-back request drops hold for 4 clocks whatever the arbitration state.
// - write-back during a dma cycle floats the upper local address drivers.
// - an isa master asserting its master signal forces address enable low.
// - refresh strobe is driven low in refresh, left to an isa master owner.
// - isa i/o strobes are driven only in dma cycles, inputs otherwise.
// - isa memory strobes are driven only in dma cycles, sampled otherwise.
// - low-meg read strobe always driven, low when read strobe and a20-23 low.
// - low-meg write strobe always driven, low when write strobe and a20-23 low.
// - a configuration bit picks flush or grant, speed or request, on pin 1; the pin 2 bit only enables its request.
// - in flush mode the cache flush pulses each time throttling takes hold.
// - speed-select input reads low as slow and high as fast.
// - speed-select does nothing until the throttle registers are armed by software.
// - slow mode inserts hold periods to approximate an 8 mhz reference machine.
// - arbitration runs on the 1x cpu clock.
// - address enable high in dma and refresh, low for cpu and masters.
// - system reset follows only power-fail, timed like the processor reset.
package sbha_pkg;

	// ==========================================
	// register map
	localparam logic [3:0]  REG_CTRL       = 4'h0;
	localparam logic [3:0]  REG_THROTTLE   = 4'h4;
	localparam logic [3:0]  REG_STATUS     = 4'h8;

	localparam int          CTRL_PREEMPT   = 0;
	localparam int          CTRL_PIN1_LM   = 1;
	localparam int          CTRL_PIN2_LM   = 2;
	localparam int          CTRL_FLUSH_EN  = 3;
	localparam int          CTRL_THR_ARMED = 4;
	localparam logic [7:0]  CTRL_RST       = 8'h00;
	// run cycles in low half, hold cycles in high half
	localparam logic [31:0] THROTTLE_RST   = 32'h0040_00c0;

	// ==========================================
	// requester slots, lowest index wins
	localparam int          NREQ           = 6;
	localparam int          SLOT_REF       = 0;
	localparam int          SLOT_DMA       = 1;
	localparam int          SLOT_LM0       = 2;
	localparam int          SLOT_LM1       = 3;
	localparam int          SLOT_LM2       = 4;
	localparam int          SLOT_SLOW      = 5;

	// ==========================================
	// timing
	localparam int          CLK_PERIOD_NS  = 5;
	localparam int          RESET_TIME_NS  = 5000;
	localparam int          RESET_CYCLES   = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          RST_CNT_W      = 11;
	localparam logic [2:0]  WB_YIELD_CLKS  = 3'h4;

	// ==========================================
	// arbiter states, gray along idle-request-owned-release
	typedef enum logic [1:0] {
		SBHA_IDLE    = 2'b00,
		SBHA_REQUEST = 2'b01,
		SBHA_OWNED   = 2'b11,
		SBHA_RELEASE = 2'b10
	} sbha_state_t;

endpackage : sbha_pkg

/* sbha_prio.sv */
`timescale 1ns/10ps
`default_nettype none
module sbha_prio
	import sbha_pkg::*;
#(
	parameter int N = NREQ
)
(
	input  wire logic [N-1:0] req,
	output var  logic [N-1:0] win
);

	// ==========================================
	// fixed priority chain
	logic [N:0] blocked;

	assign blocked[0] = 1'b0;

	genvar i;
	generate
		for (i = 0; i < N; i++)
		begin : g_slot
			assign blocked[i+1] = blocked[i] | req[i];
			assign win[i]       = req[i] & ~blocked[i];
		end
	endgenerate

endmodule : sbha_prio
`default_nettype wire

/* sbha_arbiter.sv */
`timescale 1ns/10ps
`default_nettype none
module sbha_arbiter
	import sbha_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	// register bus
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output var  logic [31:0] avs_readdata,
	output var  logic        avs_waitrequest,
	// cpu
	output var  logic        hold_request_out,
	input  wire logic        hold_acknowledge_in,
	input  wire logic        cpu_reset_request,
	// local masters, pins 1 and 2 shared
	input  wire logic        local_master_request_0_n,
	output var  logic        local_master_grant_0_n,
	input  wire logic        local_master_request_1_n,
	output var  logic        local_master_grant_1_n,
	input  wire logic        local_master_request_2_n,
	output var  logic        local_master_grant_2_n,
	// dma side
	input  wire logic        dma_request_in,
	input  wire logic        dma_cycle_active,
	input  wire logic        dma_owner_grant_in,
	output var  logic        dma_owner_grant_out_n,
	output var  logic        dma_owner_grant_oe_n,
	output var  logic        upper_address_strap,
	input  wire logic        writeback_yield_request_n,
	output var  logic        upper_address_oe_n,
	input  wire logic        isa_master_n,
	output var  logic        address_enable,
	input  wire logic        refresh_request_in,
	output var  logic        refresh_out_n,
	output var  logic        refresh_oe_n,
	// isa command strobes
	input  wire logic        dma_io_read_n,
	input  wire logic        dma_io_write_n,
	input  wire logic        dma_mem_read_n,
	input  wire logic        dma_mem_write_n,
	input  wire logic        mem_read_in_n,
	input  wire logic        mem_write_in_n,
	output var  logic        io_read_out_n,
	output var  logic        io_write_out_n,
	output var  logic        mem_read_out_n,
	output var  logic        mem_write_out_n,
	output var  logic        command_oe_n,
	input  wire logic [3:0]  address_20_23,
	output var  logic        low_mem_read_n,
	output var  logic        low_mem_write_n,
	// resets
	input  wire logic        power_ok_input,
	output var  logic        processor_reset_out,
	output var  logic        system_reset_out
);

	// ==========================================
	// state
	typedef struct packed {
		sbha_state_t            st;
		logic [NREQ-1:0]        own;
		logic                   hold;
		logic [2:0]             wb_cnt;
		logic                   wb_prev_n;
		logic [7:0]             ctrl;
		logic [31:0]            thr;
		logic [15:0]            thr_cnt;
		logic                   slow_req;
		logic                   wait_r;
		logic [31:0]            rdata;
		logic [RST_CNT_W-1:0]   rst_cnt;
		logic                   cpu_rst;
		logic                   sys_rst;
		logic                   strap;
		logic [2:0]             lgnt_n;
		logic                   flush_n;
		logic                   dma_owner_grant_n_n;
		logic                   dma_owner_grant_n_oe_n;
		logic                   aen;
		logic                   ref_n;
		logic                   ref_oe_n;
		logic                   addr_oe_n;
		logic [3:0]             cmd_n;
		logic                   cmd_oe_n;
		logic                   smemr_n;
		logic                   smemw_n;
	} sbha_regs_t;

	sbha_regs_t s_q;
	sbha_regs_t s_d;

	logic [NREQ-1:0] req;
	logic [NREQ-1:0] win;
	logic            slow_on;
	logic            owned;
	logic            cmd_drive;
	logic            memr_src;
	logic            memw_src;
	logic            leave;

	// ==========================================
	// requests
	// speed pin reads low as slow, and only once software armed the throttle
	assign slow_on = s_q.ctrl[CTRL_THR_ARMED] & ~s_q.ctrl[CTRL_PIN1_LM]
	                 & ~local_master_request_1_n;

	always_comb
	begin
		req            = '0;
		req[SLOT_REF]  = refresh_request_in;
		req[SLOT_DMA]  = dma_request_in;
		req[SLOT_LM0]  = ~local_master_request_0_n;
		req[SLOT_LM1]  = ~local_master_request_1_n & s_q.ctrl[CTRL_PIN1_LM];
		req[SLOT_LM2]  = ~local_master_request_2_n & s_q.ctrl[CTRL_PIN2_LM];
		req[SLOT_SLOW] = s_q.slow_req;
	end

	sbha_prio #(
		.N   (NREQ)
	) u_prio (
		.req (req),
		.win (win)
	);

	assign owned     = (s_q.st == SBHA_OWNED);
	assign cmd_drive = owned & s_q.own[SLOT_DMA] & dma_cycle_active & isa_master_n;
	assign memr_src  = cmd_drive ? dma_mem_read_n : mem_read_in_n;
	assign memw_src  = cmd_drive ? dma_mem_write_n : mem_write_in_n;

	// ==========================================
	// next state
	always_comb
	begin
		s_d   = s_q;
		leave = 1'b0;

		// reset sequencing, system reset only from power-fail
		if (!power_ok_input)
		begin
			s_d.rst_cnt = '0;
			s_d.cpu_rst = 1'b1;
			s_d.sys_rst = 1'b1;
		end
		else if (s_q.cpu_rst)
		begin
			if (s_q.rst_cnt == RST_CNT_W'(RESET_CYCLES - 1))
			begin
				s_d.cpu_rst = 1'b0;
				s_d.sys_rst = 1'b0;
			end
			else
			begin
				s_d.rst_cnt = s_q.rst_cnt + 1'b1;
			end
		end
		else if (cpu_reset_request)
		begin
			s_d.rst_cnt = '0;
			s_d.cpu_rst = 1'b1;
		end

		// strap sampled while the grant pin is an input
		if (!power_ok_input || s_q.sys_rst)
		begin
			s_d.strap = dma_owner_grant_in;
		end

		// write-back yield, restarted on each new assertion
		s_d.wb_prev_n = writeback_yield_request_n;
		if (!writeback_yield_request_n && s_q.wb_prev_n)
		begin
			s_d.wb_cnt = WB_YIELD_CLKS;
		end
		else if (s_q.wb_cnt != 3'h0)
		begin
			s_d.wb_cnt = s_q.wb_cnt - 1'b1;
		end

		// throttle timer: run period, then hold period
		if (!slow_on)
		begin
			s_d.slow_req = 1'b0;
			s_d.thr_cnt  = s_q.thr[15:0];
		end
		else if (!s_q.slow_req)
		begin
			if (s_q.thr_cnt == 16'h0000)
			begin
				s_d.slow_req = 1'b1;
				s_d.thr_cnt  = s_q.thr[31:16];
			end
			else
			begin
				s_d.thr_cnt = s_q.thr_cnt - 1'b1;
			end
		end
		else if (owned && s_q.own[SLOT_SLOW] && s_q.thr_cnt != 16'h0000)
		begin
			s_d.thr_cnt = s_q.thr_cnt - 1'b1;
		end

		// arbitration
		s_d.flush_n = 1'b1;
		case (s_q.st)
			SBHA_IDLE:
			begin
				s_d.own = '0;
				if (req != '0 && !s_q.sys_rst)
				begin
					s_d.st = SBHA_REQUEST;
				end
			end
			SBHA_REQUEST:
			begin
				// hold_acknowledge_in taken as is, the cpu keeps it synchronous
				if (req == '0)
				begin
					s_d.st = SBHA_IDLE;
				end
				else if (hold_acknowledge_in && s_q.hold)
				begin
					s_d.st  = SBHA_OWNED;
					s_d.own = win;
					if (win[SLOT_SLOW] && s_q.ctrl[CTRL_FLUSH_EN] && !s_q.ctrl[CTRL_PIN1_LM])
					begin
						s_d.flush_n = 1'b0;
					end
				end
			end
			SBHA_OWNED:
			begin
				if (s_q.own[SLOT_SLOW])
				begin
					leave = (s_q.thr_cnt == 16'h0000) || !slow_on;
					if (leave)
					begin
						s_d.slow_req = 1'b0;
						s_d.thr_cnt  = s_q.thr[15:0];
					end
				end
				else
				begin
					leave = (s_q.own & req) == '0;
				end
				// preemption takes a local master off for dma
				if (s_q.ctrl[CTRL_PREEMPT] && dma_request_in && (s_q.own[SLOT_LM2:SLOT_LM0] != 3'b000))
				begin
					leave = 1'b1;
				end
				if (leave || s_q.sys_rst)
				begin
					s_d.st = SBHA_RELEASE;
				end
			end
			default:
			begin
				s_d.own = '0;
				s_d.st  = SBHA_IDLE;
			end
		endcase

		// hold falls during the yield window whatever the state
		s_d.hold = (s_d.st != SBHA_IDLE) && (s_d.wb_cnt == 3'h0);

		// grants only in owned state, after hold_acknowledge_in was seen
		s_d.lgnt_n[0] = ~(s_d.st == SBHA_OWNED && s_d.own[SLOT_LM0]);
		s_d.lgnt_n[1] = ~(s_d.st == SBHA_OWNED && s_d.own[SLOT_LM1]);
		s_d.lgnt_n[2] = ~(s_d.st == SBHA_OWNED && s_d.own[SLOT_LM2]);

		// dma grant pin: input while in reset, else grant
		s_d.dma_owner_grant_n_oe_n = ~power_ok_input | s_d.sys_rst;
		s_d.dma_owner_grant_n_n    = ~(s_d.st == SBHA_OWNED && s_d.own[SLOT_DMA]);

		// address enable: dma and refresh only, never with an isa master
		s_d.aen = (s_d.st == SBHA_OWNED) && (s_d.own[SLOT_DMA] || s_d.own[SLOT_REF])
		          && isa_master_n;

		// refresh strobe, left floating for an isa master owner
		s_d.ref_n    = ~((s_d.st == SBHA_OWNED) && s_d.own[SLOT_REF]);
		s_d.ref_oe_n = s_d.ref_n | ~isa_master_n;

		// upper address lines released to the cpu during its write-back
		s_d.addr_oe_n = ~((s_d.st == SBHA_OWNED) && s_d.own[SLOT_DMA] && dma_cycle_active
		                  && (s_d.wb_cnt == 3'h0));

		// command strobes driven only in dma cycles
		s_d.cmd_oe_n = ~cmd_drive;
		s_d.cmd_n    = {dma_mem_write_n, dma_mem_read_n, dma_io_write_n, dma_io_read_n};
		s_d.smemr_n  = ~(~memr_src && (address_20_23 == 4'h0));
		s_d.smemw_n  = ~(~memw_src && (address_20_23 == 4'h0));

		// register bus: one wait cycle, commit when waitrequest is low
		s_d.wait_r = ~((avs_read | avs_write) & s_q.wait_r);
		if (avs_read && s_q.wait_r)
		begin
			if (avs_address == REG_CTRL)
			begin
				s_d.rdata = {24'h000000, s_q.ctrl};
			end
			else if (avs_address == REG_THROTTLE)
			begin
				s_d.rdata = s_q.thr;
			end
			else if (avs_address == REG_STATUS)
			begin
				s_d.rdata = {16'h0000, s_q.strap, s_q.sys_rst, slow_on, hold_acknowledge_in,
				             s_q.hold, s_q.st, s_q.wb_cnt, s_q.own};
			end
			else
			begin
				s_d.rdata = 32'h00000000;
			end
		end
		if (avs_write && !s_q.wait_r)
		begin
			if (avs_address == REG_CTRL)
			begin
				s_d.ctrl = avs_writedata[7:0];
			end
			else if (avs_address == REG_THROTTLE)
			begin
				s_d.thr = avs_writedata;
			end
		end
	end

	// ==========================================
	// registers, all on the 1x cpu clock
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			s_q           <= '0;
			s_q.st        <= SBHA_IDLE;
			s_q.wb_prev_n <= 1'b1;
			s_q.ctrl      <= CTRL_RST;
			s_q.thr       <= THROTTLE_RST;
			s_q.thr_cnt   <= THROTTLE_RST[15:0];
			s_q.wait_r    <= 1'b1;
			s_q.cpu_rst   <= 1'b1;
			s_q.sys_rst   <= 1'b1;
			s_q.strap     <= 1'b1;
			s_q.lgnt_n    <= 3'b111;
			s_q.flush_n   <= 1'b1;
			s_q.dma_owner_grant_n_n    <= 1'b1;
			s_q.dma_owner_grant_n_oe_n <= 1'b1;
			s_q.ref_n     <= 1'b1;
			s_q.ref_oe_n  <= 1'b1;
			s_q.addr_oe_n <= 1'b1;
			s_q.cmd_n     <= 4'hf;
			s_q.cmd_oe_n  <= 1'b1;
			s_q.smemr_n   <= 1'b1;
			s_q.smemw_n   <= 1'b1;
		end
		else if (clk_en)
		begin
			s_q <= s_d;
		end
	end

	// ==========================================
	// outputs
	assign avs_readdata          = s_q.rdata;
	assign avs_waitrequest       = s_q.wait_r;
	assign hold_request_out      = s_q.hold;
	assign local_master_grant_0_n = s_q.lgnt_n[0];
	// shared pin: grant 1 or cache flush
	assign local_master_grant_1_n = s_q.ctrl[CTRL_PIN1_LM] ? s_q.lgnt_n[1] : s_q.flush_n;
	assign local_master_grant_2_n = s_q.lgnt_n[2];
	assign dma_owner_grant_out_n = s_q.dma_owner_grant_n_n;
	assign dma_owner_grant_oe_n  = s_q.dma_owner_grant_n_oe_n;
	assign upper_address_strap   = s_q.strap;
	assign upper_address_oe_n    = s_q.addr_oe_n;
	assign address_enable        = s_q.aen;
	assign refresh_out_n         = s_q.ref_n;
	assign refresh_oe_n          = s_q.ref_oe_n;
	assign io_read_out_n         = s_q.cmd_n[0];
	assign io_write_out_n        = s_q.cmd_n[1];
	assign mem_read_out_n        = s_q.cmd_n[2];
	assign mem_write_out_n       = s_q.cmd_n[3];
	assign command_oe_n          = s_q.cmd_oe_n;
	assign low_mem_read_n        = s_q.smemr_n;
	assign low_mem_write_n       = s_q.smemw_n;
	assign processor_reset_out   = s_q.cpu_rst;
	assign system_reset_out      = s_q.sys_rst;

endmodule : sbha_arbiter
`default_nettype wire

/* sbha_cpu_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// cpu hold handshake
module sbha_cpu_model
(
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic [2:0] cpu_hold_lat,
	input  wire logic       hold_request_out,
	output var  logic       hold_acknowledge_in
);
	logic [2:0] wait_q;
	// ack only after the chosen delay, dropped with hold
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n || !hold_request_out)
		begin
			wait_q <= 3'h0;
			hold_acknowledge_in <= 1'b0;
		end
		else if (wait_q >= cpu_hold_lat)
			hold_acknowledge_in <= 1'b1;
		else
			wait_q <= wait_q + 3'h1;
	end
endmodule : sbha_cpu_model
`default_nettype wire

/* sbha_arbiter_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// pin checks
module sbha_checker
(
	input wire logic       sys_clk,
	input wire logic       rst_n,
	input wire logic       hold_request_out,
	input wire logic       hold_acknowledge_in,
	input wire logic       local_master_grant_0_n,
	input wire logic       local_master_grant_2_n,
	input wire logic       dma_owner_grant_out_n,
	input wire logic       dma_owner_grant_oe_n,
	input wire logic       writeback_yield_request_n,
	input wire logic       upper_address_oe_n,
	input wire logic       isa_master_n,
	input wire logic       address_enable,
	input wire logic       command_oe_n,
	input wire logic       mem_read_out_n,
	input wire logic       mem_write_out_n,
	input wire logic       mem_read_in_n,
	input wire logic       mem_write_in_n,
	input wire logic [3:0] address_20_23,
	input wire logic       low_mem_read_n,
	input wire logic       low_mem_write_n,
	input wire logic       system_reset_out
);
	logic dma_owner_grant_n;
	assign dma_owner_grant_n = !dma_owner_grant_out_n && !dma_owner_grant_oe_n;
	// strobe pins carry our own drive during dma, the bus value otherwise
	logic a_hi;
	logic ext_rd;
	logic ext_wr;
	assign a_hi   = |address_20_23;
	assign ext_rd = mem_read_in_n || a_hi;
	assign ext_wr = mem_write_in_n || a_hi;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_wb_fall;
		$fell(writeback_yield_request_n);
	endsequence
	// lag of one or two edges allowed, so only three are pinned
	sequence s_hold_off;
		##2 !hold_request_out [*3];
	endsequence
	AST_WB_HOLD: assert property (s_wb_fall |-> s_hold_off)
		else $error("hold kept during yield");
	AST_WB_FLOAT: assert property (s_wb_fall |-> ##2 upper_address_oe_n)
		else $error("address not floated");
	AST_GNT_HOLD_ACKNOWLEDGE_IN: assert property ($fell(local_master_grant_0_n) |-> $past(hold_acknowledge_in))
		else $error("grant before ack");
	AST_AEN_ISA: assert property (!isa_master_n |=> !address_enable)
		else $error("aen high with isa master");
	AST_ONE_OWNER: assert property ($onehot0({!local_master_grant_0_n, !local_master_grant_2_n, dma_owner_grant_n}))
		else $error("two owners");
	AST_CMD_DMA: assert property (!command_oe_n |-> dma_owner_grant_n)
		else $error("strobes driven outside dma");
	AST_LOW_READ: assert property (1'b1 |=> low_mem_read_n ==
		(command_oe_n ? $past(ext_rd) : (mem_read_out_n || $past(a_hi))))
		else $error("low read strobe wrong");
	AST_LOW_WRITE: assert property (1'b1 |=> low_mem_write_n ==
		(command_oe_n ? $past(ext_wr) : (mem_write_out_n || $past(a_hi))))
		else $error("low write strobe wrong");
	AST_STRAP_IN: assert property (system_reset_out && $past(system_reset_out) |-> dma_owner_grant_oe_n)
		else $error("strap pin driven");
endmodule : sbha_checker
`default_nettype wire

/* system_bus_hold_arbiter_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module system_bus_hold_arbiter_tb
	import sbha_pkg::*;
;
	// ==========================================
	// pins and model state
	logic        sys_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, cpu_reset_request = 1'b0;
	logic [3:0]  avs_address = 4'h0, address_20_23 = 4'h0, cmd;
	logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, wv, rng = 32'h48;
	logic        local_master_request_0_n = 1'b1, local_master_request_1_n = 1'b1, local_master_request_2_n = 1'b1;
	logic        local_master_grant_0_n, local_master_grant_1_n, local_master_grant_2_n;
	logic        hold_request_out, hold_acknowledge_in, dma_request_in = 1'b0, dma_cycle_active = 1'b0;
	logic        dma_owner_grant_in = 1'b1, dma_owner_grant_out_n, dma_owner_grant_oe_n, upper_address_strap;
	logic        writeback_yield_request_n = 1'b1, upper_address_oe_n, isa_master_n = 1'b1, address_enable;
	logic        refresh_request_in = 1'b0, refresh_out_n, refresh_oe_n, power_ok_input = 1'b1;
	logic        dma_io_read_n = 1'b1, dma_io_write_n = 1'b1, dma_mem_read_n = 1'b1, dma_mem_write_n = 1'b1;
	logic        mem_read_in_n = 1'b1, mem_write_in_n = 1'b1, io_read_out_n, io_write_out_n, mem_read_out_n;
	logic        mem_write_out_n, command_oe_n, low_mem_read_n, low_mem_write_n;
	logic        processor_reset_out, system_reset_out;
	logic [2:0]  cpu_hold_lat = 3'h1;
	int          errors = 0, tests_run = 0, mdl[3];

	sbha_arbiter u_dut (.*);
	sbha_cpu_model u_cpu (.*);
	always #2.5 sys_clk = ~sys_clk;

	function automatic logic [31:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction : rnd

	task automatic tally_and_finish();
		if (errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : tally_and_finish

	task automatic to();
		errors++;
		$display("ERROR %0t wait ran out", $time);
		tally_and_finish();
	endtask : to

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// ==========================================
	// avalon master, holds until waitrequest low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 50);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (avs_waitrequest !== 1'b0)
			to();
	endtask : bus

	task automatic wait_for(ref logic s, input logic v);
		for (int n = 0; s !== v; n++)
		begin
			if (n == 2000)
				to();
			@(posedge sys_clk);
		end
	endtask : wait_for

	initial
	begin
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		mdl[0] = CTRL_RST;
		mdl[1] = THROTTLE_RST;
		mdl[2] = 0;
		for (int i = 0; i < 6; i++)
		begin
			cmd = (i % 3 == 2) ? 4'hc : 4'((i % 3) * 4);
			if (i >= 3)
			begin
				wv = rnd() & ((i == 3) ? 32'h1f : 32'hffffffff);
				bus(1'b1, cmd, wv);
				if (i < 5)
					mdl[i-3] = wv;
			end
			bus(1'b0, cmd, 32'h0);
			chk(rd, mdl[i % 3]);
		end
		bus(1'b1, REG_CTRL, 32'h0);
		chk({processor_reset_out, system_reset_out}, 2'b11);
		wait_for(system_reset_out, 1'b0);
		chk(processor_reset_out, 1'b0);
		chk(upper_address_strap, 1'b1);
		// slow cpu ack, refresh and local master race
		cpu_hold_lat <= 3'h5;
		refresh_request_in <= 1'b1;
		local_master_request_0_n <= 1'b0;
		wait_for(refresh_out_n, 1'b0);
		chk({local_master_grant_0_n, address_enable, refresh_oe_n}, 3'b110);
		refresh_request_in <= 1'b0;
		wait_for(local_master_grant_0_n, 1'b0);
		chk({hold_request_out, hold_acknowledge_in, address_enable}, 3'b110);
		@(posedge sys_clk);
		writeback_yield_request_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk(hold_request_out, 1'b0);
		writeback_yield_request_n <= 1'b1;
		repeat (5) @(posedge sys_clk);
		chk({hold_request_out, local_master_grant_0_n}, 2'b10);
		// dma preempts the local master
		bus(1'b1, REG_CTRL, 32'h1 << CTRL_PREEMPT);
		dma_request_in <= 1'b1;
		wait_for(local_master_grant_0_n, 1'b1);
		local_master_request_0_n <= 1'b1;
		wait_for(dma_owner_grant_out_n, 1'b0);
		wv = rnd();
		cmd = wv[3:0];
		{dma_io_read_n, dma_io_write_n, dma_mem_read_n, dma_mem_write_n} <= cmd;
		dma_cycle_active <= 1'b1;
		repeat (2) @(posedge sys_clk);
		chk({address_enable, dma_owner_grant_oe_n, command_oe_n, upper_address_oe_n}, 4'b1000);
		chk({io_read_out_n, io_write_out_n, mem_read_out_n, mem_write_out_n}, cmd);
		writeback_yield_request_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk(upper_address_oe_n, 1'b1);
		writeback_yield_request_n <= 1'b1;
		isa_master_n <= 1'b0;
		repeat (5) @(posedge sys_clk);
		chk({address_enable, command_oe_n}, 2'b01);
		{isa_master_n, dma_request_in, dma_cycle_active} <= 3'b100;
		wait_for(hold_request_out, 1'b0);
		chk(dma_owner_grant_out_n, 1'b1);
		for (int i = 0; i < 16; i++)
		begin
			wv = rnd();
			address_20_23 <= (i < 4) ? 4'h0 : wv[3:0];
			{mem_read_in_n, mem_write_in_n} <= wv[5:4];
			repeat (2) @(posedge sys_clk);
			chk(low_mem_read_n, mem_read_in_n | (|address_20_23));
			chk(low_mem_write_n, mem_write_in_n | (|address_20_23));
		end
		// shared pins: two more local masters, lower index wins
		bus(1'b1, REG_CTRL, (32'h1 << CTRL_PIN1_LM) | (32'h1 << CTRL_PIN2_LM));
		{local_master_request_1_n, local_master_request_2_n} <= 2'b00;
		wait_for(local_master_grant_1_n, 1'b0);
		chk(local_master_grant_2_n, 1'b1);
		local_master_request_1_n <= 1'b1;
		wait_for(local_master_grant_2_n, 1'b0);
		local_master_request_2_n <= 1'b1;
		wait_for(hold_request_out, 1'b0);
		// speed pin: dead until armed, then run and hold periods
		bus(1'b1, REG_THROTTLE, 32'h0005_0003);
		bus(1'b1, REG_CTRL, 32'h0);
		local_master_request_1_n <= 1'b0;
		repeat (20) @(posedge sys_clk);
		chk(hold_request_out, 1'b0);
		bus(1'b1, REG_CTRL, (32'h1 << CTRL_THR_ARMED) | (32'h1 << CTRL_FLUSH_EN));
		wait_for(local_master_grant_1_n, 1'b0);
		wait_for(hold_request_out, 1'b0);
		wait_for(hold_request_out, 1'b1);
		local_master_request_1_n <= 1'b1;
		wait_for(hold_request_out, 1'b0);
		repeat (40) @(posedge sys_clk);
		chk(hold_request_out, 1'b0);
		bus(1'b0, REG_STATUS, 32'h0);
		chk(rd, 32'h0000_8000);
		// processor-only reset leaves the system reset alone
		cpu_reset_request <= 1'b1;
		@(posedge sys_clk);
		cpu_reset_request <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk({processor_reset_out, system_reset_out}, 2'b10);
		wait_for(processor_reset_out, 1'b0);
		// power fail re-samples the strap
		power_ok_input <= 1'b0;
		dma_owner_grant_in <= 1'b0;
		repeat (4) @(posedge sys_clk);
		chk({system_reset_out, dma_owner_grant_oe_n, upper_address_strap}, 3'b110);
		tally_and_finish();
	end
endmodule : system_bus_hold_arbiter_tb

bind sbha_arbiter sbha_checker u_chk (.*);
`default_nettype wire
